// file: clock_gen_pkg.sv
// Shared constants for the clock generation and halt supervision block
package clock_gen_pkg;
    localparam int unsigned MCLK_HZ = 50000000;
    localparam int unsigned HALT_TIMEOUT_NS = 2000;
    localparam int unsigned HALT_TIMEOUT_CYCLES = (HALT_TIMEOUT_NS * (MCLK_HZ / 1000000)) / 1000;
    localparam int unsigned HALT_CNT_W = 8;
    localparam int unsigned FORCED_PINS = 12;
    localparam int unsigned SYS_DIV_W = 13;
    localparam int unsigned PER_DIV_W = 10;
    localparam int unsigned MSTBY_W = 8;
    localparam logic [7:0] MSTBY_RESET = 8'hFF;
    localparam logic [1:0] OP_MODE_SINGLE = 2'h3;
    localparam logic [1:0] CMODE_X1 = 2'h0;
    localparam logic [1:0] CMODE_X2 = 2'h1;
    localparam logic [1:0] CMODE_X4 = 2'h2;
    localparam logic [1:0] CMODE_X4_P2 = 2'h3;
    localparam logic [2:0] MULT_X1 = 3'h1;
    localparam logic [2:0] MULT_X2 = 3'h2;
    localparam logic [2:0] MULT_X4 = 3'h4;
    localparam logic [12:0] SYS_DIV_ONE = 13'h0001;
    localparam logic [9:0] PER_DIV_ONE = 10'h001;
endpackage

// file: clock_prescaler_if.sv
// Connection between the clock generator and its prescaler chain
`timescale 1ns/1ps
`default_nettype none
interface clock_prescaler_if;
    logic sys_tick;
    logic per_tick;
    logic [clock_gen_pkg::SYS_DIV_W-1:0] sys_taps;
    logic [clock_gen_pkg::PER_DIV_W-1:0] per_taps;
    modport gen (output sys_tick, output per_tick, input sys_taps, input per_taps);
    modport scaler (input sys_tick, input per_tick, output sys_taps, output per_taps);
endinterface
`default_nettype wire

// file: clock_prescaler.sv
// Binary prescaler chains for the system and peripheral clock ticks
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Tick in, prescaled taps out
    clock_prescaler_if.scaler pre
);
    logic [clock_gen_pkg::SYS_DIV_W-1:0] sys_cnt;
    logic [clock_gen_pkg::PER_DIV_W-1:0] per_cnt;

    // Bit k of each counter toggles at the tick rate over 2^(k+1)
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sys_cnt <= '0;
        end else if (pre.sys_tick) begin
            sys_cnt <= sys_cnt + clock_gen_pkg::SYS_DIV_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            per_cnt <= '0;
        end else if (pre.per_tick) begin
            per_cnt <= per_cnt + clock_gen_pkg::PER_DIV_ONE;
        end
    end

    assign pre.sys_taps = sys_cnt;
    assign pre.per_taps = per_cnt;
endmodule
`default_nettype wire

// file: clock_gen_halt_detect.sv
// Clock mode decode, prescaled clocks and oscillator halt supervision
// Behaviour
// - Only single-chip mode supported; others flagged.
// - System clock is input times one, two, four.
// - Mode pins select multipliers; 11 gives peripheral x2.
// - Prescaled taps sys/2..8192, peripheral/2..1024.
// - Selected modules start in module standby.
// - Missing input edges float twelve timer pins.
// - Standby floats the twelve timer pins.
// - Leaving standby restores configured pin behaviour unless undefined state is latched.
// - Halt outside standby latches undefined state.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_halt_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Oscillator input, sampled
    input wire logic clock_input_pin,
    // Mode straps
    input wire logic [1:0] op_mode_pins,
    input wire logic clock_mode_pin_low,
    input wire logic clock_mode_pin_high,
    // Standby control
    input wire logic standby,
    input wire logic [7:0] mstby_clear,
    // Timer pins as configured by pin_function_setting
    input wire logic [11:0] timer_out,
    input wire logic [11:0] timer_oe,
    // Clock outputs
    output logic [2:0] sys_mult,
    output logic [2:0] per_mult,
    output logic [12:0] sys_prescaled,
    output logic [9:0] per_prescaled,
    // Status
    output logic mode_unsupported,
    output logic clock_halted,
    output logic halt_undefined,
    output logic [7:0] module_standby,
    // Timer pin drive
    output logic [11:0] timer_pin_out,
    output logic [11:0] timer_pin_oe
);
    clock_prescaler_if pre ();

    logic in_prev;
    logic [clock_gen_pkg::HALT_CNT_W-1:0] idle_cnt;
    logic next_halted;
    logic halt_event;
    logic float_pins;
    logic input_rise;
    logic [2:0] ratio_cnt;
    logic [2:0] per_ratio_cnt;
    logic [1:0] cmode;

    // Straps read as one two-bit code, high pin first
    assign cmode = {clock_mode_pin_high, clock_mode_pin_low};

    function automatic logic [2:0] sys_mult_of(input logic [1:0] m);
        case (m)
            clock_gen_pkg::CMODE_X1: sys_mult_of = clock_gen_pkg::MULT_X1;
            clock_gen_pkg::CMODE_X2: sys_mult_of = clock_gen_pkg::MULT_X2;
            default: sys_mult_of = clock_gen_pkg::MULT_X4;
        endcase
    endfunction

    function automatic logic [2:0] per_mult_of(input logic [1:0] m);
        if (m == clock_gen_pkg::CMODE_X4_P2) begin
            per_mult_of = clock_gen_pkg::MULT_X2;
        end else begin
            per_mult_of = sys_mult_of(m);
        end
    endfunction

    // Burst counter steps down to zero and rests there
    function automatic logic [2:0] burst_next(input logic [2:0] cnt);
        if (cnt != 3'h0) begin
            burst_next = cnt - 3'h1;
        end else begin
            burst_next = 3'h0;
        end
    endfunction

    // Multiplier selection; straps must not change while powered
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sys_mult <= clock_gen_pkg::MULT_X1;
            per_mult <= clock_gen_pkg::MULT_X1;
        end else begin
            sys_mult <= sys_mult_of(cmode);
            per_mult <= per_mult_of(cmode);
        end
    end

    // Extension modes are only reported; nothing else reacts to them
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode_unsupported <= 1'b0;
        end else begin
            mode_unsupported <= (op_mode_pins != clock_gen_pkg::OP_MODE_SINGLE);
        end
    end

    // Edge detect on the input clock and timeout counted on mclk
    // Resets to the idle-high level so releasing reset fakes no rising edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            in_prev <= 1'b1;
        end else begin
            in_prev <= clock_input_pin;
        end
    end

    // Standby resets the timer: a stopped external clock is expected there
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            idle_cnt <= '0;
        end else if (standby || clock_input_pin != in_prev) begin
            idle_cnt <= '0;
        end else if (!next_halted) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Counter saturates at the limit so a long halt never wraps into a false recovery
    assign next_halted = (32'(idle_cnt) >= clock_gen_pkg::HALT_TIMEOUT_CYCLES - 1);

    // A parked source in standby is expected and is not a halt
    assign halt_event = next_halted && !standby;

    // Level follows the detector and drops again once edges return
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            clock_halted <= 1'b0;
        end else begin
            clock_halted <= halt_event;
        end
    end

    // Sticky: no recovery even if oscillation resumes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            halt_undefined <= 1'b0;
        end else if (halt_event) begin
            halt_undefined <= 1'b1;
        end
    end

    // Pin override beats any pin function selection
    assign float_pins = standby || next_halted || halt_undefined;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            timer_pin_oe <= '0;
        end else if (float_pins) begin
            timer_pin_oe <= '0;
        end else begin
            timer_pin_oe <= timer_oe;
        end
    end

    // Data is parked low while floated so nothing stale shows on release
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            timer_pin_out <= '0;
        end else if (float_pins) begin
            timer_pin_out <= '0;
        end else begin
            timer_pin_out <= timer_out;
        end
    end

    // Module standby starts set, software clears bits
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            module_standby <= clock_gen_pkg::MSTBY_RESET;
        end else begin
            module_standby <= module_standby & ~mstby_clear;
        end
    end

    // Rising input edge; ignored in standby, where the source is parked high
    assign input_rise = clock_input_pin && !in_prev && !standby;

    // Tick generation: ticks per input edge by multiplier, modelled on mclk
    // Limitation: input edges must lie further apart than the largest multiplier
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ratio_cnt <= '0;
        end else if (input_rise) begin
            ratio_cnt <= sys_mult;
        end else begin
            ratio_cnt <= burst_next(ratio_cnt);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            per_ratio_cnt <= '0;
        end else if (input_rise) begin
            per_ratio_cnt <= per_mult;
        end else begin
            per_ratio_cnt <= burst_next(per_ratio_cnt);
        end
    end

    // One tick stands for each multiplied clock period
    assign pre.sys_tick = (ratio_cnt != 3'h0);
    assign pre.per_tick = (per_ratio_cnt != 3'h0);

    clock_prescaler u_prescaler (
        .mclk(mclk),
        .resetn(resetn),
        .pre(pre)
    );

    // Registered copy keeps every output on a flip-flop
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sys_prescaled <= '0;
            per_prescaled <= '0;
        end else begin
            sys_prescaled <= pre.sys_taps;
            per_prescaled <= pre.per_taps;
        end
    end
endmodule
`default_nettype wire

// file: clock_gen_chk_assertions.sv
// Port checker for the clock generator and halt supervisor
`timescale 1ns/1ps
`default_nettype none
module clock_gen_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Inputs watched
    input wire logic clock_input_pin,
    input wire logic [1:0] op_mode_pins,
    input wire logic clock_mode_pin_low,
    input wire logic clock_mode_pin_high,
    input wire logic standby,
    input wire logic [7:0] mstby_clear,
    input wire logic [11:0] timer_oe,
    // Outputs watched
    input wire logic [2:0] sys_mult,
    input wire logic [2:0] per_mult,
    input wire logic mode_unsupported,
    input wire logic clock_halted,
    input wire logic halt_undefined,
    input wire logic [7:0] module_standby,
    input wire logic [11:0] timer_pin_oe
);
    logic live;
    logic in_q;
    logic [7:0] idle;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Skips the first edge after reset, where outputs still hold reset values
    always_ff @(posedge mclk) live <= resetn;
    always_ff @(posedge mclk) begin
        in_q <= clock_input_pin;
        idle <= (standby || !resetn || in_q != clock_input_pin) ? 8'h00 :
            idle + {7'h00, idle != 8'hFF};
    end
    property p_mode; live |-> mode_unsupported == ($past(op_mode_pins) != 2'h3); endproperty
    a_mode: assert property (p_mode) else $error("mode flag wrong");
    property p_sys; live |-> sys_mult == ($past(clock_mode_pin_high) ? 3'h4 :
        ($past(clock_mode_pin_low) ? 3'h2 : 3'h1)); endproperty
    a_sys: assert property (p_sys) else $error("system multiplier wrong");
    property p_per; live |-> per_mult == ($past(clock_mode_pin_high) ?
        ($past(clock_mode_pin_low) ? 3'h2 : 3'h4) : ($past(clock_mode_pin_low) ? 3'h2 : 3'h1));
        endproperty
    a_per: assert property (p_per) else $error("peripheral multiplier wrong");
    property p_mrst; $rose(resetn) |-> module_standby == 8'hFF; endproperty
    a_mrst: assert property (p_mrst) else $error("module standby reset wrong");
    property p_mclr; live |-> (module_standby & $past(mstby_clear)) == 8'h00; endproperty
    a_mclr: assert property (p_mclr) else $error("module standby not cleared");
    property p_halt; clock_halted |-> timer_pin_oe == 12'h000; endproperty
    a_halt: assert property (p_halt) else $error("pins driven while halted");
    property p_stby; live && $past(standby) |-> timer_pin_oe == 12'h000; endproperty
    a_stby: assert property (p_stby) else $error("pins driven in standby");
    property p_norm; live && !$past(standby) && !clock_halted && !halt_undefined
        |-> timer_pin_oe == $past(timer_oe); endproperty
    a_norm: assert property (p_norm) else $error("pin enables not passed");
    property p_undef; halt_undefined |=> halt_undefined; endproperty
    a_undef: assert property (p_undef) else $error("undefined state lost");
    // Slack of ten cycles covers the detector's own pipeline
    property p_tmo; idle >= 8'h6E |-> clock_halted; endproperty
    a_tmo: assert property (p_tmo) else $error("halt not detected");
endmodule
bind clock_gen_halt_detect clock_gen_chk u_chk (.mclk, .resetn, .clock_input_pin,
    .op_mode_pins, .clock_mode_pin_low, .clock_mode_pin_high, .standby, .mstby_clear,
    .timer_oe, .sys_mult, .per_mult, .mode_unsupported, .clock_halted, .halt_undefined,
    .module_standby, .timer_pin_oe);
`default_nettype wire

// file: ext_clock_source.sv
// External clock source model with adjustable rate
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
    // Bench control
    input wire logic mclk,
    input wire logic run,
    input wire logic standby,
    input wire logic [3:0] half,
    // Clock to the device
    output logic clk_out
);
    int cnt = 0;
    initial clk_out = 1'b1;
    // Changes on the falling edge so the sampler never sees a race
    always @(negedge mclk) begin
        if (standby) begin
            clk_out <= 1'b1;
            cnt <= 0;
        end else if (run) begin
            cnt <= (cnt + 1) % half;
            if (cnt == half - 1) clk_out <= !clk_out;
        end
    end
endmodule
`default_nettype wire

// file: clock_gen_halt_detect_tb_top.sv
// Self-checking bench for the clock generator and halt supervisor
`timescale 1ns/1ps
`default_nettype none
module clock_gen_halt_detect_tb_top;
    logic mclk = 1'b0, resetn = 1'b0, run = 1'b0, standby = 1'b0, ml = 1'b0, mh = 1'b0, osc;
    logic [1:0] opm = 2'h3;
    logic [3:0] half = 4'h3;
    logic [7:0] clr = 8'h00, mstby;
    logic [11:0] t_out = 12'h000, t_oe = 12'h000, pin_out, pin_oe;
    logic [2:0] sys_mult, per_mult;
    logic [12:0] sys_pre;
    logic [9:0] per_pre;
    logic unsup, halted, undef;
    int err_count = 0, total_checks = 0, seed = 20, i, exp_ms = 255;
    always #10 mclk = ~mclk;
    ext_clock_source src (.mclk, .run, .standby, .half, .clk_out(osc));
    clock_gen_halt_detect uut (.mclk, .resetn, .clock_input_pin(osc), .op_mode_pins(opm),
        .clock_mode_pin_low(ml), .clock_mode_pin_high(mh), .standby, .mstby_clear(clr),
        .timer_out(t_out), .timer_oe(t_oe), .sys_mult, .per_mult, .sys_prescaled(sys_pre),
        .per_prescaled(per_pre), .mode_unsupported(unsup), .clock_halted(halted),
        .halt_undefined(undef), .module_standby(mstby), .timer_pin_out(pin_out),
        .timer_pin_oe(pin_oe));
    int sys_exp = 0, per_exp = 0, m_s = 1, m_p = 1;
    logic osc_q = 1'b1;
    // Reference: each rising input edge outside standby adds one tick per multiple
    always @(posedge mclk) begin
        osc_q <= resetn ? osc : 1'b1;
        m_s <= !resetn ? 1 : (mh ? 4 : (ml ? 2 : 1));
        m_p <= !resetn ? 1 : (mh ? (ml ? 2 : 4) : (ml ? 2 : 1));
        if (!resetn) begin
            sys_exp <= 0;
            per_exp <= 0;
        end else if (osc && !osc_q && !standby) begin
            sys_exp <= sys_exp + m_s;
            per_exp <= per_exp + m_p;
        end
    end
    task chk(input string what, input logic [12:0] exp, input logic [12:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task finish_test;
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    initial begin
        cyc(16);
        resetn = 1'b1;
        cyc(1);
        chk("mstby", 8'hFF, mstby);
        run = 1'b1;
        cyc(20);
        for (i = 0; i < 16; i++) begin
            {opm, mh, ml} = i[3:0];
            clr = i[0] ? 8'h01 << i[3:1] : 8'h00;
            exp_ms &= ~clr;
            t_oe = 12'($random(seed));
            t_out = 12'($random(seed));
            cyc(1);
            chk("unsup", opm != 2'h3, unsup);
            chk("sys_mult", mh ? 3'h4 : (ml ? 3'h2 : 3'h1), sys_mult);
            chk("per_mult", (mh & ml) ? 3'h2 : (mh ? 3'h4 : (ml ? 3'h2 : 3'h1)), per_mult);
            chk("mstby", exp_ms[7:0], mstby);
            chk("pin_oe", t_oe, pin_oe);
            chk("pin_out", t_out, pin_out);
        end
        clr = 8'h00;
        standby = 1'b1;
        cyc(1);
        chk("pin_oe", 12'h000, pin_oe);
        cyc(200);
        chk("halted", 1'b0, halted);
        chk("sys_pre", sys_exp[12:0], sys_pre);
        chk("per_pre", per_exp[9:0], per_pre);
        standby = 1'b0;
        cyc(1);
        chk("pin_oe", t_oe, pin_oe);
        half = 4'h7;
        cyc(60);
        chk("pin_oe", t_oe, pin_oe);
        run = 1'b0;
        cyc(115);
        chk("halted", 1'b1, halted);
        chk("pin_oe", 12'h000, pin_oe);
        chk("sys_pre", sys_exp[12:0], sys_pre);
        chk("per_pre", per_exp[9:0], per_pre);
        run = 1'b1;
        cyc(20);
        chk("undef", 1'b1, undef);
        chk("pin_oe", 12'h000, pin_oe);
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(1);
        chk("undef", 1'b0, undef);
        chk("mstby", 8'hFF, mstby);
        chk("sys_pre", sys_exp[12:0], sys_pre);
        finish_test;
    end
    initial begin
        cyc(5000);
        err_count++;
        finish_test;
    end
endmodule
`default_nettype wire
